// ---- hw/usbgef_defines.svh ----
// constants for the usb global event flag block
//
// Contract
// - configured flag clears on hardware reset and on bus reset (SE0 >= 2.7 us)
// - wake flag (bit 5) sets on bus activity while suspended, not own resume
// - usb interrupt high while wake flag and its enable are both set
// - reset-end flag (bit 4) sets at end of bus reset; raises irq when enabled
// - frame-start flag (bit 3) sets on SOF PID; raises irq when enabled
// - suspend flag (bit 0) sets after 3 ms idle J; raises irq when enabled
// - event flags stay set until firmware clears them
// - reserved event bits 7-6, 2, 1 read zero; firmware writes them zero
// - enable register resets to 10h, only reset-end enable set
`ifndef USBGEF_DEFINES_SVH
`define USBGEF_DEFINES_SVH

// register indices; byte address is four times the index
`define USBGEF_CTRL_IDX      8'hbc
`define USBGEF_EVT_IDX       8'hbd
`define USBGEF_EN_IDX        8'hbe
`define USBGEF_CTRL_ADDR     ({2'h0, `USBGEF_CTRL_IDX, 2'h0})
`define USBGEF_EVT_ADDR      ({2'h0, `USBGEF_EVT_IDX, 2'h0})
`define USBGEF_EN_ADDR       ({2'h0, `USBGEF_EN_IDX, 2'h0})

// field positions
`define USBGEF_BIT_WAKE      5
`define USBGEF_BIT_RST_END   4
`define USBGEF_BIT_SOF       3
`define USBGEF_BIT_SUSP      0
`define USBGEF_BIT_CFG       1

// implemented bit masks and reset values
`define USBGEF_EVT_MASK      8'h39
`define USBGEF_CTRL_MASK     8'h02
`define USBGEF_EVT_RST       8'h00
`define USBGEF_EN_RST        8'h10
`define USBGEF_CTRL_RST      8'h00
`define USBGEF_BYTE_ZERO     8'h00
`define USBGEF_WORD_ZERO     32'h0000_0000

// line states as {dp, dm}
`define USBGEF_LINE_J        2'b10
`define USBGEF_LINE_SE0      2'b00

// timing
`define USBGEF_CLK_NS        20
`define USBGEF_BUS_RST_NS    2700
`define USBGEF_BUS_RST_CYC   ((`USBGEF_BUS_RST_NS + `USBGEF_CLK_NS - 1) / `USBGEF_CLK_NS)
`define USBGEF_SUSP_MS       3
`define USBGEF_SUSP_CYC      ((`USBGEF_SUSP_MS * 1000000) / `USBGEF_CLK_NS)
`define USBGEF_TMR_W         18

`endif

// ---- hw/usbgef_pkg.sv ----
// types shared by the usb global event flag block
package usbgef_pkg;
	typedef logic [11:0] usbgef_addr_t;
	typedef logic [31:0] usbgef_word_t;
	typedef logic [1:0]  usbgef_line_t;
	typedef enum logic [1:0] {
		USBGEF_ST_ACTIVE  = 2'b00,
		USBGEF_ST_BUS_RST = 2'b01,
		USBGEF_ST_SUSP    = 2'b10
	} usbgef_state_t;
endpackage

// ---- hw/usbgef_sync.sv ----
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module usbgef_sync #(
	parameter int          W    = 2,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q_r  <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q_r <= s3_r; // glitch of one cycle never reaches q
			end
		end
	end

	assign q = q_r;
endmodule

// ---- hw/usbgef_hold_timer.sv ----
// counts cycles a level is held and reports when the hold time is reached
`timescale 1ns/1ps
module usbgef_hold_timer #(
	parameter int W = 18,
	parameter int N = 135
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level,
	output logic      expired
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         hit;

	// saturate at the limit so expired stays up while the level holds
	assign hit     = (cnt_r == W'(N));
	assign cnt_nxt = !level ? '0 : (hit ? cnt_r : cnt_r + 1'b1);
	assign expired = hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// ---- hw/usbgef_top.sv ----
// usb global event flags with apb register access and one interrupt line
`timescale 1ns/1ps
`include "usbgef_defines.svh"
module usbgef_top #(
	parameter int SUSP_CYC = `USBGEF_SUSP_CYC
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire usbgef_pkg::usbgef_addr_t paddr,
	input  wire usbgef_pkg::usbgef_word_t pwdata,
	output usbgef_pkg::usbgef_word_t      prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   usb_dp,
	input  wire logic                   usb_dm,
	input  wire logic                   sof_pid_det,
	input  wire logic                   upstream_resume,
	output logic                        usb_irq,
	output logic                        usb_suspended,
	output logic                        configured_flag
);
	import usbgef_pkg::*;

	usbgef_line_t  line;
	usbgef_state_t st_r;
	usbgef_state_t st_nxt;
	logic [7:0]    flags_r;
	logic [7:0]    flags_nxt;
	logic [7:0]    en_r;
	logic [7:0]    en_nxt;
	logic          cfg_r;
	logic          cfg_nxt;
	logic [7:0]    ev;
	logic [7:0]    clr_mask;
	logic [7:0]    rd_byte;
	usbgef_word_t  prdata_r;
	logic          pslverr_r;
	logic          line_j;
	logic          line_se0;
	logic          se0_long;
	logic          idle_long;
	logic          hit_ctrl;
	logic          hit_evt;
	logic          hit_en;
	logic          hit_any;
	logic          setup_ph;
	logic          wr_acc;
	logic          wr_evt;
	logic          wr_en;
	logic          wr_ctrl;
	logic          go_bus_rst;
	logic          go_susp;
	logic          go_rst_end;
	logic          go_wake;
	logic          leave_susp;

	// pins come from outside the clock domain
	usbgef_sync #(
		.W    (2),
		.INIT (`USBGEF_LINE_J)
	) u_line_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({usb_dp, usb_dm}),
		.q       (line)
	);

	assign line_j   = (line == `USBGEF_LINE_J);
	assign line_se0 = (line == `USBGEF_LINE_SE0);

	// se0 long enough to count as a bus reset
	usbgef_hold_timer #(
		.W (`USBGEF_TMR_W),
		.N (`USBGEF_BUS_RST_CYC)
	) u_se0_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (line_se0),
		.expired (se0_long)
	);

	// continuous idle j before suspend
	usbgef_hold_timer #(
		.W (`USBGEF_TMR_W),
		.N (SUSP_CYC)
	) u_idle_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (line_j),
		.expired (idle_long)
	);

	// apb decode; zero wait states, read data captured in setup
	assign hit_ctrl = (paddr == `USBGEF_CTRL_ADDR);
	assign hit_evt  = (paddr == `USBGEF_EVT_ADDR);
	assign hit_en   = (paddr == `USBGEF_EN_ADDR);
	assign hit_any  = hit_ctrl | hit_evt | hit_en;
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite & hit_any;
	assign wr_evt   = wr_acc & hit_evt;
	assign wr_en    = wr_acc & hit_en;
	assign wr_ctrl  = wr_acc & hit_ctrl;
	assign pready   = 1'b1;
	assign pslverr  = pslverr_r & psel & penable;
	assign prdata   = prdata_r;

	// read mux; reserved bits are never stored so read zero
	assign rd_byte = hit_evt  ? flags_r :
	                 hit_en   ? en_r :
	                 hit_ctrl ? {6'h00, cfg_r, 1'b0} : `USBGEF_BYTE_ZERO;

	// link state tracking
	assign go_bus_rst = (st_r != USBGEF_ST_BUS_RST) & se0_long;
	assign go_susp    = (st_r == USBGEF_ST_ACTIVE) & idle_long & ~se0_long;
	assign go_rst_end = (st_r == USBGEF_ST_BUS_RST) & ~line_se0;
	assign leave_susp = (st_r == USBGEF_ST_SUSP) & ~line_j;
	assign go_wake    = leave_susp & ~upstream_resume; // own resume is not a wake

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			USBGEF_ST_ACTIVE: begin
				if (se0_long) begin
					st_nxt = USBGEF_ST_BUS_RST;
				end else if (idle_long) begin
					st_nxt = USBGEF_ST_SUSP;
				end
			end
			USBGEF_ST_BUS_RST: begin
				if (!line_se0) begin
					st_nxt = USBGEF_ST_ACTIVE;
				end
			end
			USBGEF_ST_SUSP: begin
				if (se0_long) begin
					st_nxt = USBGEF_ST_BUS_RST;
				end else if (!line_j) begin
					st_nxt = USBGEF_ST_ACTIVE;
				end
			end
			default: begin
				st_nxt = USBGEF_ST_ACTIVE;
			end
		endcase
	end

	// event vector in register layout
	always_comb begin
		ev = `USBGEF_BYTE_ZERO;
		ev[`USBGEF_BIT_WAKE]    = go_wake;
		ev[`USBGEF_BIT_RST_END] = go_rst_end;
		ev[`USBGEF_BIT_SOF]     = sof_pid_det;
		ev[`USBGEF_BIT_SUSP]    = go_susp;
	end

	// write one to clear; the event ors in last so it wins
	assign clr_mask  = wr_evt ? pwdata[7:0] : `USBGEF_BYTE_ZERO;
	assign flags_nxt = ((flags_r & ~clr_mask) | ev) & `USBGEF_EVT_MASK;
	assign en_nxt    = wr_en ? (pwdata[7:0] & `USBGEF_EVT_MASK) : en_r;
	// bus reset beats a firmware set in the same cycle
	assign cfg_nxt   = go_bus_rst ? 1'b0 : (wr_ctrl ? pwdata[`USBGEF_BIT_CFG] : cfg_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= USBGEF_ST_ACTIVE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// flag, enable and control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= `USBGEF_EVT_RST;
			en_r    <= `USBGEF_EN_RST;
			cfg_r   <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			en_r    <= en_nxt;
			cfg_r   <= cfg_nxt;
		end
	end

	// read data and error flag settle in setup, stand through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= `USBGEF_WORD_ZERO;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r  <= {24'h000000, rd_byte};
			pslverr_r <= ~hit_any;
		end
	end

	// level interrupt from any enabled flag
	assign usb_irq         = |(flags_r & en_r);
	assign usb_suspended   = (st_r == USBGEF_ST_SUSP);
	assign configured_flag = cfg_r;

	// helper state for checks
	logic init_done_r;
	logic wake_ok;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_r <= 1'b0;
		end else begin
			init_done_r <= 1'b1;
		end
	end
	assign wake_ok = (st_r == USBGEF_ST_SUSP) & ~upstream_resume & ~line_j;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cfg_bus_rst;
		se0_long && (st_r == USBGEF_ST_ACTIVE) |=> !cfg_r && (st_r == USBGEF_ST_BUS_RST);
	endproperty
	a_cfg_bus_rst: assert property (p_cfg_bus_rst) else $error("configured kept over bus reset");

	property p_wake_set;
		wake_ok |=> flags_r[`USBGEF_BIT_WAKE] && (st_r != USBGEF_ST_SUSP);
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set on activity");

	property p_wake_cause;
		$rose(flags_r[`USBGEF_BIT_WAKE]) |-> $past(wake_ok);
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake flag set without cause");

	property p_wake_irq;
		flags_r[`USBGEF_BIT_WAKE] && en_r[`USBGEF_BIT_WAKE] |-> usb_irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt missing");

	property p_rst_end;
		(st_r == USBGEF_ST_BUS_RST) && !line_se0 |=> flags_r[`USBGEF_BIT_RST_END]
			&& (!en_r[`USBGEF_BIT_RST_END] || usb_irq);
	endproperty
	a_rst_end: assert property (p_rst_end) else $error("reset end flag not set");

	property p_sof;
		sof_pid_det |=> flags_r[`USBGEF_BIT_SOF] && (!en_r[`USBGEF_BIT_SOF] || usb_irq);
	endproperty
	a_sof: assert property (p_sof) else $error("frame start flag not set");

	property p_susp_cause;
		$rose(flags_r[`USBGEF_BIT_SUSP]) |-> $past(idle_long) && usb_suspended;
	endproperty
	a_susp_cause: assert property (p_susp_cause) else $error("suspend flag without idle");

	property p_susp_irq;
		flags_r[`USBGEF_BIT_SUSP] && en_r[`USBGEF_BIT_SUSP] |-> usb_irq;
	endproperty
	a_susp_irq: assert property (p_susp_irq) else $error("suspend interrupt missing");

	property p_sticky;
		!wr_evt |=> ((flags_r & $past(flags_r)) == $past(flags_r));
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared without write");

	property p_rsvd;
		psel && penable && !pwrite && hit_evt |-> (prdata[7:6] == 2'b00) && (prdata[2:1] == 2'b00);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

	property p_en_rst;
		!init_done_r |-> (en_r == `USBGEF_EN_RST);
	endproperty
	a_en_rst: assert property (p_en_rst) else $error("enable reset value wrong");

	property p_set_wins;
		wr_evt && pwdata[`USBGEF_BIT_SOF] && sof_pid_det |=> flags_r[`USBGEF_BIT_SOF];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

	// the device's own resume may leave suspend but never wakes the cpu
	property p_wake_own;
		upstream_resume |=> !$rose(flags_r[`USBGEF_BIT_WAKE]);
	endproperty
	a_wake_own: assert property (p_wake_own) else $error("own resume set wake flag");

	property p_susp_entry;
		(st_r == USBGEF_ST_ACTIVE) && idle_long && !se0_long
			|=> usb_suspended && flags_r[`USBGEF_BIT_SUSP];
	endproperty
	a_susp_entry: assert property (p_susp_entry) else $error("idle j did not suspend");

	// a write of one with no event pending does clear the flag
	property p_w1c;
		wr_evt && pwdata[`USBGEF_BIT_SOF] && !sof_pid_det |=> !flags_r[`USBGEF_BIT_SOF];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by write");

	property p_en_rsvd;
		(en_r & ~`USBGEF_EVT_MASK) == `USBGEF_BYTE_ZERO;
	endproperty
	a_en_rsvd: assert property (p_en_rsvd) else $error("reserved enable bit set");

	c_bus_rst: cover property ((st_r == USBGEF_ST_BUS_RST) ##[1:200] flags_r[`USBGEF_BIT_RST_END]);
	c_susp_wake: cover property (usb_suspended ##[1:50] flags_r[`USBGEF_BIT_WAKE]);
	c_sof_irq: cover property (sof_pid_det ##1 usb_irq);
	c_w1c: cover property (wr_evt && (flags_r != `USBGEF_BYTE_ZERO));
	c_own_resume: cover property (usb_suspended && upstream_resume ##1 !usb_suspended);
endmodule

// ---- verification/usbgef_host_model.sv ----
// behavioural usb host driving the bus line pins and the frame-start strobe
`timescale 1ns/1ps
`include "usbgef_defines.svh"
module usbgef_host_model (
	input  wire logic pclk,
	output logic      usb_dp,
	output logic      usb_dm,
	output logic      sof_pid_det
);
	// idle bus reads as j, as the device pull-up makes it
	initial begin
		{usb_dp, usb_dm} = `USBGEF_LINE_J;
		sof_pid_det      = 1'h0;
	end
	// hold a line state for n clocks; long se0 is a bus reset, long j a suspend
	task automatic line(input logic [1:0] st, input int n);
		{usb_dp, usb_dm} <= st;
		repeat (n) @(posedge pclk);
	endtask
	// one-clock frame-start strobe, called just after an edge
	task automatic sof;
		sof_pid_det <= 1'h1;
		@(posedge pclk);
		sof_pid_det <= 1'h0;
	endtask
endmodule

// ---- verification/tb_usb_global_event_flags.sv ----
// self-checking bench for the usb global event flag block
`timescale 1ns/1ps
`include "usbgef_defines.svh"
module tb_usb_global_event_flags;
	import usbgef_pkg::*;
	localparam int           SUSP = 400;
	localparam usbgef_addr_t A_CT = `USBGEF_CTRL_ADDR;
	localparam usbgef_addr_t A_EV = `USBGEF_EVT_ADDR;
	localparam usbgef_addr_t A_EN = `USBGEF_EN_ADDR;
	localparam logic [1:0]   K    = 2'h1;
	logic         pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic         upstream_resume = 1'h0, err;
	usbgef_addr_t paddr = 12'h0;
	usbgef_word_t pwdata = 32'h0, prdata, rd;
	logic         pready, pslverr, usb_dp, usb_dm, sof_pid_det;
	logic         usb_irq, usb_suspended, configured_flag;
	int           failures = 0, n_compared = 0;
	// rows: address, written byte, byte read back, error expected
	usbgef_addr_t row_a [4] = '{A_CT, A_EN, A_EV, 12'h100};
	logic [7:0]   row_w [4] = '{8'hff, 8'h39, 8'h39, 8'hff};
	logic [7:0]   row_r [4] = '{8'h02, 8'h39, 8'h00, 8'h00};
	logic         row_e [4] = '{1'h0, 1'h0, 1'h0, 1'h1};

	usbgef_top #(.SUSP_CYC(SUSP)) u_usbgef_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .usb_dp(usb_dp), .usb_dm(usb_dm),
		.sof_pid_det(sof_pid_det), .upstream_resume(upstream_resume), .usb_irq(usb_irq),
		.usb_suspended(usb_suspended), .configured_flag(configured_flag));
	usbgef_host_model u_usbgef_host_model (.pclk(pclk), .usb_dp(usb_dp), .usb_dm(usb_dm),
		.sof_pid_det(sof_pid_det));

	// 50 mhz clock
	initial begin
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input usbgef_addr_t a, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// hang guard, well past the roughly 1200 cycles the tests need
	initial begin
		repeat (8000) @(posedge pclk);
		failures++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		apb(A_EN, 0, 8'h0); chk(rd, 32'h10);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h0);
		apb(A_CT, 0, 8'h0); chk(rd, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			apb(row_a[i], 1, row_w[i]);
			apb(row_a[i], 0, 8'h0);
			chk(rd, {24'h0, row_r[i]});
			chk(32'(err), 32'(row_e[i]));
		end
		chk(32'(configured_flag), 32'h1);
		$display("register rows done");
		// frame start, masking and a clear colliding with a new event
		apb(A_EN, 1, 8'h08);
		u_usbgef_host_model.sof();
		@(posedge pclk);
		chk(32'(usb_irq), 32'h1);
		repeat (20) @(posedge pclk);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h08);
		apb(A_EN, 1, 8'h00);
		@(posedge pclk);
		chk(32'(usb_irq), 32'h0);
		apb(A_EN, 1, 8'h08);
		fork
			apb(A_EV, 1, 8'h08);
			begin
				repeat (2) @(posedge pclk);
				u_usbgef_host_model.sof();
			end
		join
		apb(A_EV, 0, 8'h0); chk(rd, 32'h08);
		apb(A_EV, 1, 8'h08);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h0);
		$display("frame start test done");
		// bus reset drops configured and flags its end
		apb(A_EN, 1, 8'h10);
		u_usbgef_host_model.line(`USBGEF_LINE_SE0, 150);
		u_usbgef_host_model.line(`USBGEF_LINE_J, 10);
		chk(32'(configured_flag), 32'h0);
		chk(32'(usb_irq), 32'h1);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h10);
		apb(A_EV, 1, 8'h10);
		$display("bus reset test done");
		// idle j long enough to suspend
		apb(A_EN, 1, 8'h21);
		u_usbgef_host_model.line(`USBGEF_LINE_J, SUSP + 20);
		chk(32'(usb_suspended), 32'h1);
		chk(32'(usb_irq), 32'h1);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h01);
		apb(A_EV, 1, 8'h01);
		// own resume signalling leaves suspend without waking the cpu
		upstream_resume <= 1'h1;
		u_usbgef_host_model.line(K, 20);
		u_usbgef_host_model.line(`USBGEF_LINE_J, 8);
		upstream_resume <= 1'h0;
		chk(32'(usb_suspended), 32'h0);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h0);
		// host resume while suspended wakes the cpu
		u_usbgef_host_model.line(`USBGEF_LINE_J, SUSP + 20);
		u_usbgef_host_model.line(K, 20);
		u_usbgef_host_model.line(`USBGEF_LINE_J, 8);
		chk(32'(usb_suspended), 32'h0);
		chk(32'(usb_irq), 32'h1);
		apb(A_EV, 0, 8'h0); chk(rd, 32'h21);
		// clocks assumed back on before the clear
		apb(A_EV, 1, 8'h21);
		@(posedge pclk);
		chk(32'(usb_irq), 32'h0);
		$display("suspend and wake test done");
		// firmware clears configured; a mid-run hardware reset clears it and the flags
		apb(A_CT, 1, 8'h02);
		apb(A_CT, 0, 8'h0); chk(rd, 32'h02);
		apb(A_CT, 1, 8'h00);
		apb(A_CT, 0, 8'h0); chk(rd, 32'h0);
		apb(A_CT, 1, 8'h02);
		apb(A_EN, 1, 8'h08);
		u_usbgef_host_model.sof();
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk(32'(configured_flag), 32'h0);
		chk(32'(usb_irq), 32'h0);
		presetn <= 1'h1;
		apb(A_EV, 0, 8'h0); chk(rd, 32'h0);
		apb(A_EN, 0, 8'h0); chk(rd, 32'h10);
		$display("mid-run reset test done");
		complete_run;
	end
endmodule
